// file: logic/sbe_pkg.sv
// constants and types for the serial boot entry and autobaud loader port
// assumes a single 50 MHz ref_clk domain and a plain register port
package sbe_pkg;
    localparam logic [7:0] SBE_SYNC_BYTE = 8'h7F;
    // fall of start bit to fall of bit 7 of the sync byte spans 8 bits
    localparam int SBE_SYNC_SPAN_SHIFT = 3;
    localparam logic [3:0] SBE_FRAME_BITS = 4'hB;
    localparam logic [3:0] SBE_RX_PAR_IDX = 4'hA;
    localparam logic [3:0] SBE_RX_STOP_IDX = 4'hB;
    localparam logic [1:0] SBE_STRAP_WAIT = 2'h2;
    localparam logic [4:0] SBE_ADDR_STATUS = 5'h00;
    localparam logic [4:0] SBE_ADDR_RXDATA = 5'h04;
    localparam logic [4:0] SBE_ADDR_TXDATA = 5'h08;
    localparam logic [4:0] SBE_ADDR_BAUD = 5'h0C;
    localparam logic [4:0] SBE_ADDR_CTRL = 5'h10;
    localparam int SBE_CTRL_CLR_FRM = 0;
    localparam int SBE_CTRL_CLR_OVR = 1;
    localparam int SBE_STAT_MAP = 8;
    localparam int SBE_STAT_LOADER = 9;
    localparam int SBE_STAT_FRM = 10;
    localparam int SBE_STAT_OVR = 11;
    localparam int SBE_STAT_RXAV = 12;
    localparam int SBE_STAT_TXBUSY = 13;
    localparam int SBE_CLK_HZ = 50_000_000;
    localparam int SBE_REFRESH_US = 1000;
    localparam int SBE_REFRESH_CYC = SBE_CLK_HZ / 1_000_000 * SBE_REFRESH_US;
    localparam logic [7:0] SBE_SYS_CLK_MHZ = 8'h18;
    localparam logic [2:0] SBE_FLASH_WAIT = 3'h1;
    localparam logic [2:0] SBE_WDG_PRESC_MAX = 3'h7;
    localparam logic [31:0] SBE_OPTION_ADDR = 32'h1FFF_F800;
    localparam logic [31:0] SBE_RAM_BASE = 32'h2000_0000;
    localparam logic [31:0] SBE_RAM_BYTES = 32'h0000_0800;
    localparam logic [31:0] SBE_RAM_LAST = SBE_RAM_BASE + SBE_RAM_BYTES - 32'h1;
    typedef enum logic [5:0] {
        SBE_ST_OFF = 6'h01,
        SBE_ST_DETECT = 6'h02,
        SBE_ST_MEASURE = 6'h04,
        SBE_ST_SYNCEND = 6'h08,
        SBE_ST_CMD = 6'h10,
        SBE_ST_APP = 6'h20
    } sbe_state_t;
endpackage : sbe_pkg

// file: logic/sbe_boot.sv
// boot entry, mapping detection, autobaud and 8E1 loader serial port
// assumes the board holds the unused receive pin at a steady level
`timescale 1ns/1ps
`default_nettype none

module sbe_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);
    localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wptr;
        logic [AW-1:0] rptr;
        logic [AW:0] count;
    } sbe_fifo_t;
    sbe_fifo_t s;
    sbe_fifo_t next_s;
    logic push;
    logic pop;

    assign in_ready = (s.count != FULL);
    assign out_valid = (s.count != '0);
    assign out_data = s.mem[s.rptr];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        next_s = s;
        if (push) begin
            next_s.mem[s.wptr] = in_data;
            next_s.wptr = (s.wptr == LAST) ? '0 : s.wptr + 1'b1;
        end
        if (pop) begin
            next_s.rptr = (s.rptr == LAST) ? '0 : s.rptr + 1'b1;
        end
        if (push && !pop) begin
            next_s.count = s.count + 1'b1;
        end else if (pop && !push) begin
            next_s.count = s.count - 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end
endmodule : sbe_fifo

module sbe_boot
    import sbe_pkg::*;
#(
    parameter int REFRESH_CYC = SBE_REFRESH_CYC,
    parameter int FIFO_DEPTH = 8
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic boot_select_pin,
    input wire logic boot_option_bit,
    input wire logic loader_receive_pin_a,
    input wire logic loader_receive_pin_b,
    output logic loader_transmit_pin_a,
    output logic loader_transmit_pin_b,
    input wire logic app_clock_out,
    input wire logic app_rts_out,
    output logic app_cts_in,
    output logic serial_clock_out_pin,
    output logic request_to_send_pin,
    input wire logic clear_to_send_pin,
    input wire logic [4:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic loader_active,
    output logic swd_enable,
    output logic sys_clk_from_pll,
    output logic [7:0] sys_clk_mhz,
    output logic [2:0] flash_wait_states,
    output logic [2:0] wdg_prescaler,
    output logic wdg_refresh,
    output logic ram_reserve_en,
    output logic [31:0] ram_reserve_base,
    output logic [31:0] ram_reserve_last
);
    localparam int WW = $clog2(REFRESH_CYC + 1);
    localparam logic [WW-1:0] WDG_LAST = WW'(REFRESH_CYC - 1);
    typedef struct packed {
        logic bsel_s1;
        logic bsel_s2;
        logic rxa_s1;
        logic rxa_s2;
        logic rxa_prev;
        logic rxb_s1;
        logic rxb_s2;
        logic rxb_prev;
        logic [1:0] strap_cnt;
        logic loader;
        sbe_state_t st;
        logic map_b;
        logic [15:0] tick;
        logic [15:0] bit_per;
        logic [15:0] rx_cnt;
        logic [3:0] rx_bit;
        logic [8:0] rx_shift;
        logic [7:0] rx_hold;
        logic rx_pend;
        logic frm_err;
        logic ovr;
        logic tx_busy;
        logic [15:0] tx_cnt;
        logic [3:0] tx_bit;
        logic [10:0] tx_shift;
        logic tx_line;
        logic [WW-1:0] wdg_cnt;
        logic wdg_pulse;
        logic [31:0] rdata;
    } sbe_boot_t;
    sbe_boot_t s;
    sbe_boot_t next_s;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [7:0] fifo_out_data;
    logic rx_pop;
    logic line;
    logic line_prev;
    logic fall_a;
    logic fall_b;
    logic fall_sel;
    logic rise_sel;

    assign line = s.map_b ? s.rxb_s2 : s.rxa_s2;
    assign line_prev = s.map_b ? s.rxb_prev : s.rxa_prev;
    assign fall_a = s.rxa_prev && !s.rxa_s2;
    assign fall_b = s.rxb_prev && !s.rxb_s2;
    assign fall_sel = line_prev && !line;
    assign rise_sel = !line_prev && line;
    assign rx_pop = reg_rd && (reg_addr == SBE_ADDR_RXDATA);

    // received bytes wait here; a full buffer holds the receiver's byte
    sbe_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .in_valid(s.rx_pend),
        .in_ready(fifo_in_ready),
        .in_data(s.rx_hold),
        .out_valid(fifo_out_valid),
        .out_ready(rx_pop),
        .out_data(fifo_out_data)
    );

    always_comb begin
        next_s = s;
        next_s.bsel_s1 = boot_select_pin;
        next_s.bsel_s2 = s.bsel_s1;
        next_s.rxa_s1 = loader_receive_pin_a;
        next_s.rxa_s2 = s.rxa_s1;
        next_s.rxa_prev = s.rxa_s2;
        next_s.rxb_s1 = loader_receive_pin_b;
        next_s.rxb_s2 = s.rxb_s1;
        next_s.rxb_prev = s.rxb_s2;
        next_s.wdg_pulse = 1'b0;
        if (s.rx_pend && fifo_in_ready) begin
            next_s.rx_pend = 1'b0;
        end
        // software clear goes first so a same-cycle hardware set wins
        if (reg_wr && reg_addr == SBE_ADDR_CTRL) begin
            if (reg_wdata[SBE_CTRL_CLR_FRM]) begin
                next_s.frm_err = 1'b0;
            end
            if (reg_wdata[SBE_CTRL_CLR_OVR]) begin
                next_s.ovr = 1'b0;
            end
        end
        case (s.st)
            SBE_ST_OFF: begin
                // strap sampled once sync chain is filled
                if (s.strap_cnt == SBE_STRAP_WAIT) begin
                    next_s.loader = s.bsel_s2 && boot_option_bit;
                    next_s.st = (s.bsel_s2 && boot_option_bit) ?
                        SBE_ST_DETECT : SBE_ST_APP;
                end else begin
                    next_s.strap_cnt = s.strap_cnt + 1'b1;
                end
            end
            SBE_ST_DETECT: begin
                // poll both mappings, first falling edge wins
                if (fall_a || fall_b) begin
                    next_s.map_b = !fall_a;
                    next_s.tick = '0;
                    next_s.st = SBE_ST_MEASURE;
                end
            end
            SBE_ST_MEASURE: begin
                // tick times start fall to bit 7 fall
                next_s.tick = s.tick + 1'b1;
                if (fall_sel) begin
                    next_s.bit_per = 16'((17'(s.tick) + 17'h1)
                        >> SBE_SYNC_SPAN_SHIFT);
                    next_s.st = SBE_ST_SYNCEND;
                end else if (&s.tick) begin
                    next_s.st = SBE_ST_DETECT;
                end
            end
            SBE_ST_SYNCEND: begin
                // skip parity and stop of sync, then commands
                if (s.bit_per == '0) begin
                    next_s.st = SBE_ST_DETECT;
                end else if (rise_sel) begin
                    next_s.rx_cnt = s.bit_per + (s.bit_per >> 1);
                end else if (line && s.rx_cnt != '0) begin
                    next_s.rx_cnt = s.rx_cnt - 1'b1;
                    if (s.rx_cnt == 16'h0001) begin
                        next_s.st = SBE_ST_CMD;
                    end
                end
            end
            SBE_ST_CMD: begin
                if (s.rx_bit == '0) begin
                    if (fall_sel) begin
                        next_s.rx_bit = 4'h1;
                        next_s.rx_cnt = s.bit_per >> 1;
                    end
                end else if (s.rx_cnt != '0) begin
                    next_s.rx_cnt = s.rx_cnt - 1'b1;
                end else begin
                    next_s.rx_cnt = s.bit_per - 1'b1;
                    next_s.rx_bit = s.rx_bit + 1'b1;
                    if (s.rx_bit == 4'h1 && line) begin
                        next_s.rx_bit = '0;
                    end else if (s.rx_bit > 4'h1 &&
                                 s.rx_bit <= SBE_RX_PAR_IDX) begin
                        next_s.rx_shift = {line, s.rx_shift[8:1]};
                    end else if (s.rx_bit == SBE_RX_STOP_IDX) begin
                        next_s.rx_bit = '0;
                        if ((^s.rx_shift) || !line) begin
                            next_s.frm_err = 1'b1;
                        end
                        // holding byte still unaccepted: newest is lost
                        if (s.rx_pend && !fifo_in_ready) begin
                            next_s.ovr = 1'b1;
                        end else begin
                            next_s.rx_hold = s.rx_shift[7:0];
                            next_s.rx_pend = 1'b1;
                        end
                    end
                end
            end
            SBE_ST_APP: begin
                next_s.st = SBE_ST_APP;
            end
            default: begin
                next_s.st = SBE_ST_OFF;
            end
        endcase
        if (s.tx_busy) begin
            if (s.tx_cnt != '0) begin
                next_s.tx_cnt = s.tx_cnt - 1'b1;
            end else begin
                next_s.tx_cnt = s.bit_per - 1'b1;
                next_s.tx_shift = {1'b1, s.tx_shift[10:1]};
                next_s.tx_line = s.tx_shift[1];
                next_s.tx_bit = s.tx_bit - 1'b1;
                if (s.tx_bit == 4'h1) begin
                    next_s.tx_busy = 1'b0;
                    next_s.tx_line = 1'b1;
                end
            end
        end else if (reg_wr && reg_addr == SBE_ADDR_TXDATA &&
                     s.st == SBE_ST_CMD) begin
            next_s.tx_busy = 1'b1;
            next_s.tx_shift = {1'b1, ^reg_wdata[7:0], reg_wdata[7:0], 1'b0};
            next_s.tx_line = 1'b0;
            next_s.tx_cnt = s.bit_per - 1'b1;
            next_s.tx_bit = SBE_FRAME_BITS;
        end
        // periodic refresh while the loader runs
        if (s.loader) begin
            if (s.wdg_cnt == WDG_LAST) begin
                next_s.wdg_cnt = '0;
                next_s.wdg_pulse = 1'b1;
            end else begin
                next_s.wdg_cnt = s.wdg_cnt + 1'b1;
            end
        end
        next_s.rdata = '0;
        if (reg_rd) begin
            case (reg_addr)
                SBE_ADDR_STATUS: begin
                    next_s.rdata[5:0] = s.st;
                    next_s.rdata[SBE_STAT_MAP] = s.map_b;
                    next_s.rdata[SBE_STAT_LOADER] = s.loader;
                    next_s.rdata[SBE_STAT_FRM] = s.frm_err;
                    next_s.rdata[SBE_STAT_OVR] = s.ovr;
                    next_s.rdata[SBE_STAT_RXAV] = fifo_out_valid;
                    next_s.rdata[SBE_STAT_TXBUSY] = s.tx_busy;
                end
                SBE_ADDR_RXDATA: begin
                    next_s.rdata[7:0] = fifo_out_valid ? fifo_out_data : 8'h00;
                end
                SBE_ADDR_BAUD: begin
                    next_s.rdata[15:0] = s.bit_per;
                end
                default: begin
                    next_s.rdata = '0;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            s <= '0;
            s.st <= SBE_ST_OFF;
            s.tx_line <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    // only the selected mapping drives traffic; the other idles high
    assign loader_transmit_pin_a = s.map_b || s.tx_line;
    assign loader_transmit_pin_b = !s.map_b || s.tx_line;
    // these pins stay with the application
    assign serial_clock_out_pin = app_clock_out;
    assign request_to_send_pin = app_rts_out;
    assign app_cts_in = clear_to_send_pin;
    assign reg_rdata = s.rdata;
    assign loader_active = s.loader;
    // debug clock pin belongs to the loader until reset
    assign swd_enable = !s.loader && s.st == SBE_ST_APP;
    // clock and wait-state request while the loader runs
    assign sys_clk_from_pll = s.loader;
    assign sys_clk_mhz = s.loader ? SBE_SYS_CLK_MHZ : 8'h00;
    assign flash_wait_states = s.loader ? SBE_FLASH_WAIT : 3'h0;
    assign wdg_prescaler = s.loader ? SBE_WDG_PRESC_MAX : 3'h0;
    assign wdg_refresh = s.wdg_pulse;
    assign ram_reserve_en = s.loader;
    assign ram_reserve_base = SBE_RAM_BASE;
    assign ram_reserve_last = SBE_RAM_LAST;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    AST_BOOT_ENTRY: assert property ($rose(s.loader) |->
        $past(s.bsel_s2) && boot_option_bit)
        else $error("loader entered without strap");
    AST_DETECT_A: assert property ((s.st == SBE_ST_DETECT) && fall_a
        |=> s.st == SBE_ST_MEASURE && !s.map_b)
        else $error("mapping a activity missed");
    AST_BAUD: assert property ((s.st == SBE_ST_MEASURE) && fall_sel
        |=> s.bit_per == 16'(($past(17'(s.tick)) + 17'h1) >> 3))
        else $error("bit time not from sync span");
    AST_RX_ONLY_CMD: assert property ($rose(s.rx_pend) |->
        s.st == SBE_ST_CMD && $past(s.st) == SBE_ST_CMD)
        else $error("byte received outside command wait");
    AST_TX_START: assert property ($rose(s.tx_busy) |-> !s.tx_line
        ##1 (!s.tx_line) [*1])
        else $error("start bit not low");
    AST_SWD: assert property (s.loader |=> s.loader && !swd_enable)
        else $error("debug returned before reset");
    AST_CLOCK: assert property ($rose(s.loader) |-> sys_clk_from_pll
        && flash_wait_states == 3'h1 && sys_clk_mhz == 8'h18)
        else $error("loader clock setup wrong");
    AST_WDG: assert property (wdg_refresh |-> wdg_prescaler == 3'h7
        ##1 !wdg_refresh)
        else $error("refresh without max prescaler");
    AST_RAM: assert property (ram_reserve_en |->
        ram_reserve_last - ram_reserve_base == 32'h0000_07FF)
        else $error("ram window size wrong");
    AST_PINS: assert property (!s.map_b && s.st == SBE_ST_CMD |->
        loader_transmit_pin_b && serial_clock_out_pin == app_clock_out)
        else $error("unused pin driven by loader");
endmodule : sbe_boot

`default_nettype wire

// file: testbench/sbe_host.sv
// host model: drives both loader receive pins, listens on a transmit pin
// assumes the device idles its transmit pins high and frames 8E1
`timescale 1ns/1ps
`default_nettype none
module sbe_host #(
    parameter int BIT_CYC = 16
) (
    input wire logic ref_clk,
    output logic rx_a,
    output logic rx_b,
    input wire logic tx_a,
    input wire logic tx_b
);
    // unused mapping held high, never floating
    initial begin
        rx_a = 1'b1;
        rx_b = 1'b1;
    end
    task automatic send(input logic map_b, input logic [7:0] data,
                        input logic bad_par);
        logic [10:0] frm;
        frm = {1'b1, ^data ^ bad_par, data, 1'b0};
        for (int i = 0; i < 11; i++) begin
            if (map_b) rx_b <= frm[i];
            else rx_a <= frm[i];
            repeat (BIT_CYC) @(posedge ref_clk);
        end
    endtask : send
    // bounded hunt for the start bit, then mid-bit sampling
    task automatic recv(input logic map_b, output logic [10:0] frm,
                        output logic ok);
        ok = 1'b0;
        frm = 11'h0;
        for (int n = 0; n < 400 && !ok; n++) begin
            @(posedge ref_clk);
            if ((map_b ? tx_b : tx_a) === 1'b0) ok = 1'b1;
        end
        repeat (BIT_CYC / 2) @(posedge ref_clk);
        for (int i = 0; i < 11; i++) begin
            frm[i] = map_b ? tx_b : tx_a;
            repeat (BIT_CYC) @(posedge ref_clk);
        end
    endtask : recv
endmodule : sbe_host
`default_nettype wire

// file: testbench/tb_sbe_boot.sv
// self-checking bench for the boot entry and loader serial port
// assumes sbe_pkg is compiled first; host model drives the serial side
`timescale 1ns/1ps
`default_nettype none
module tb_sbe_boot;
    import sbe_pkg::*;
    localparam int BIT = 16;
    logic ref_clk, rst_b, boot_select_pin, boot_option_bit;
    logic rx_a, rx_b, tx_a, tx_b, app_clock_out, app_rts_out, app_cts_in;
    logic serial_clock_out_pin, request_to_send_pin, clear_to_send_pin;
    logic [4:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, ram_reserve_base, ram_reserve_last;
    logic reg_wr, reg_rd, loader_active, swd_enable, sys_clk_from_pll;
    logic [7:0] sys_clk_mhz;
    logic [2:0] flash_wait_states, wdg_prescaler;
    logic wdg_refresh, ram_reserve_en, ok;
    logic [31:0] seed, rd, cnt;
    logic [10:0] frm;
    logic [7:0] d;
    int fails, total_checks;
    logic [7:0] exp_q[$];
    sbe_boot #(.REFRESH_CYC(20), .FIFO_DEPTH(8)) sbe_boot_i (
        .ref_clk(ref_clk), .rst_b(rst_b),
        .boot_select_pin(boot_select_pin), .boot_option_bit(boot_option_bit),
        .loader_receive_pin_a(rx_a), .loader_receive_pin_b(rx_b),
        .loader_transmit_pin_a(tx_a), .loader_transmit_pin_b(tx_b),
        .app_clock_out(app_clock_out), .app_rts_out(app_rts_out),
        .app_cts_in(app_cts_in), .serial_clock_out_pin(serial_clock_out_pin),
        .request_to_send_pin(request_to_send_pin),
        .clear_to_send_pin(clear_to_send_pin), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .loader_active(loader_active),
        .swd_enable(swd_enable), .sys_clk_from_pll(sys_clk_from_pll),
        .sys_clk_mhz(sys_clk_mhz), .flash_wait_states(flash_wait_states),
        .wdg_prescaler(wdg_prescaler), .wdg_refresh(wdg_refresh),
        .ram_reserve_en(ram_reserve_en), .ram_reserve_base(ram_reserve_base),
        .ram_reserve_last(ram_reserve_last));
    sbe_host #(.BIT_CYC(BIT)) sbe_host_i (.ref_clk(ref_clk), .rx_a(rx_a),
        .rx_b(rx_b), .tx_a(tx_a), .tx_b(tx_b));
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : xs
    task automatic check(input string name, input logic [31:0] exp,
                         input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask : check
    task automatic end_sim();
        $display("checks %0d fails %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_sim
    task automatic reg_write(input logic [4:0] a, input logic [31:0] v);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : reg_write
    // read data stand only in the cycle after the strobe
    task automatic reg_read(input logic [4:0] a, output logic [31:0] v);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask : reg_read
    task automatic count_wdg(input int n, output logic [31:0] c);
        c = 0;
        repeat (n) begin
            @(posedge ref_clk);
            #1 c += wdg_refresh;
        end
    endtask : count_wdg
    task automatic pass_chk();
        @(posedge ref_clk);
        seed = xs(seed);
        app_clock_out <= seed[0];
        app_rts_out <= seed[1];
        clear_to_send_pin <= seed[2];
        #1;
        check("clk out", seed[0], serial_clock_out_pin);
        check("rts", seed[1], request_to_send_pin);
        check("cts", seed[2], app_cts_in);
    endtask : pass_chk
    task automatic do_reset(input logic pin, input logic opt);
        rst_b <= 1'b0;
        boot_select_pin <= pin;
        boot_option_bit <= opt;
        repeat (2) @(posedge ref_clk);
        rst_b <= 1'b1;
        repeat (6) @(posedge ref_clk);
        #1;
    endtask : do_reset
    initial begin
        seed = 32'h88736224;
        rst_b = 1'b0;
        {boot_select_pin, boot_option_bit} = 2'h3;
        {app_clock_out, app_rts_out, clear_to_send_pin} = 3'h0;
        {reg_wr, reg_rd, reg_addr, reg_wdata} = 39'h0;
        do_reset(1'b1, 1'b1);
        check("loader", 32'h1, loader_active);
        check("swd", 32'h0, swd_enable);
        check("pll", 32'h1, sys_clk_from_pll);
        check("mhz", 32'h18, sys_clk_mhz);
        check("wait", 32'h1, flash_wait_states);
        check("presc", 32'h7, wdg_prescaler);
        check("ram en", 32'h1, ram_reserve_en);
        check("ram base", 32'h2000_0000, ram_reserve_base);
        check("ram last", 32'h2000_07FF, ram_reserve_last);
        count_wdg(200, cnt);
        check("refresh", 32'hA, cnt);
        pass_chk();
        reg_read(SBE_ADDR_STATUS, rd);
        check("detect", 32'h202, rd & 32'h33F);
        sbe_host_i.send(1'b1, SBE_SYNC_BYTE, 1'b0);
        for (int n = 0; n < 40 && rd[5:0] !== 6'h10; n++) begin
            reg_read(SBE_ADDR_STATUS, rd);
        end
        check("cmd", 32'h310, rd & 32'h33F);
        reg_read(SBE_ADDR_BAUD, rd);
        check("baud", BIT, rd);
        for (int k = 0; k < 10; k++) begin
            seed = xs(seed);
            sbe_host_i.send(1'b1, seed[7:0], 1'b0);
            if (k < 9) exp_q.push_back(seed[7:0]);
        end
        reg_read(SBE_ADDR_STATUS, rd);
        check("overrun", 32'h1800, rd & 32'h1C00);
        while (exp_q.size() > 0) begin
            reg_read(SBE_ADDR_RXDATA, rd);
            check("rx byte", exp_q.pop_front(), rd);
        end
        reg_read(SBE_ADDR_RXDATA, rd);
        check("rx empty", 32'h0, rd);
        reg_write(SBE_ADDR_CTRL, 32'h2);
        reg_read(SBE_ADDR_STATUS, rd);
        check("ovr clear", 32'h0, rd & 32'h1C00);
        sbe_host_i.send(1'b1, 8'hA5, 1'b1);
        repeat (4) @(posedge ref_clk);
        reg_read(SBE_ADDR_STATUS, rd);
        check("parity err", 32'h1400, rd & 32'h1C00);
        reg_read(SBE_ADDR_RXDATA, rd);
        check("bad byte", 32'hA5, rd);
        reg_write(SBE_ADDR_CTRL, 32'h1);
        reg_read(SBE_ADDR_STATUS, rd);
        check("err clear", 32'h0, rd & 32'h1C00);
        seed = xs(seed);
        d = seed[7:0];
        reg_write(SBE_ADDR_TXDATA, {24'h0, d});
        sbe_host_i.recv(1'b1, frm, ok);
        if (!ok) begin
            fails++;
            end_sim();
        end
        check("tx frame", {1'b1, ^d, d, 1'b0}, frm);
        check("tx a idle", 32'h1, tx_a);
        reg_read(5'h14, rd);
        check("unmapped", 32'h0, rd);
        reg_write(SBE_ADDR_BAUD, 32'hFFFF_FFFF);
        reg_read(SBE_ADDR_BAUD, rd);
        check("baud ro", BIT, rd);
        // second boot, this time the host talks on mapping a
        do_reset(1'b1, 1'b1);
        reg_read(SBE_ADDR_STATUS, rd);
        check("detect a", 32'h202, rd & 32'h33F);
        sbe_host_i.send(1'b0, SBE_SYNC_BYTE, 1'b0);
        for (int n = 0; n < 40 && rd[5:0] !== 6'h10; n++) begin
            reg_read(SBE_ADDR_STATUS, rd);
        end
        check("cmd a", 32'h210, rd & 32'h33F);
        seed = xs(seed);
        sbe_host_i.send(1'b0, seed[7:0], 1'b0);
        reg_read(SBE_ADDR_RXDATA, rd);
        check("rx a byte", {24'h0, seed[7:0]}, rd);
        check("tx b idle", 32'h1, tx_b);
        for (int m = 0; m < 2; m++) begin
            do_reset(m[0], ~m[0]);
            check("app loader", 32'h0, loader_active);
            check("app swd", 32'h1, swd_enable);
            check("app mhz", 32'h0, sys_clk_mhz);
            check("app ram", 32'h0, ram_reserve_en);
            reg_read(SBE_ADDR_STATUS, rd);
            check("app state", 32'h20, rd & 32'h23F);
            count_wdg(60, cnt);
            check("app refresh", 32'h0, cnt);
            pass_chk();
        end
        end_sim();
    end
endmodule : tb_sbe_boot
`default_nettype wire
